// *** logic/clock_edge_detect.sv ***
// edge detector for a slow clock sampled as an ordinary input
// assumes level_i is synchronous to clock_i
`timescale 1ns/1ps

module clock_edge_detect
(
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic level_i,
  output logic      rise_o,
  output logic      fall_o
);

  logic prev_reg;

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      prev_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_reg;
  assign fall_o = ~level_i & prev_reg;

endmodule // clock_edge_detect

// *** logic/sas_defs.svh ***
// constants for the eight-stage shift-and-store register
// assumes inclusion by bare name from logic/
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

`define SAS_STAGES      8
`define SAS_STAGE_RST   8'h00
`define SAS_SEVENTH_IDX 6
`define SAS_LAST_IDX    7

`endif

// *** logic/sas_pkg.sv ***
// types shared by the shift-and-store register
// assumes sas_defs.svh is on the include path
`include "sas_defs.svh"

package sas_pkg;

  typedef logic [`SAS_STAGES-1:0] stage_t;

endpackage

// *** logic/shift_and_store_register8.sv ***
// eight-stage serial shift register with storage latches, three-state
// parallel outputs and two cascade outputs
// assumes all inputs synchronous to clock_i; shift_clock_i is sampled
// Operation
// R1: eight stages shift serial input in on each rising shift clock edge.
// R2: latches follow their stages while latch transfer high, hold when low.
// R3: parallel outputs drive latches when enabled, float when disabled.
// R4: enabled, transfer low: rising edges leave parallel outputs unchanged.
// R5: enabled, transfer high: rising edge shifts serial input onto outputs.
// R6: rising edge moves seventh stage to eighth and rise serial output.
// R7: falling edge copies last stage to fall serial output only.
// R8: serial outputs update regardless of enable and never float.
// R9: cascade via rise output for fast clocks, fall output for slow.
// R10: no functional reset; contents meaningless until eight bits loaded.
`timescale 1ns/1ps
`include "sas_defs.svh"

module shift_and_store_register8
(
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic             serial_in_i,
  input  wire logic             shift_clock_i,
  input  wire logic             latch_transfer_i,
  input  wire logic             output_enable_i,
  output sas_pkg::stage_t       parallel_out_o,
  output sas_pkg::stage_t       parallel_oe_o,
  output logic                  serial_out_rise_o,
  output logic                  serial_out_fall_o
);

  // ---------------------------------------------------------------
  // shift clock edges
  // ---------------------------------------------------------------
  logic            rise;
  logic            fall;
  sas_pkg::stage_t stage_reg;
  sas_pkg::stage_t stage_next;
  sas_pkg::stage_t latch_reg;
  logic            rise_out_reg;
  logic            fall_out_reg;

  clock_edge_detect u_clock_edge_detect
  (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .level_i (shift_clock_i),
    .rise_o  (rise),
    .fall_o  (fall)
  );

  // ---------------------------------------------------------------
  // shift chain
  // ---------------------------------------------------------------
  // one shift step: the new bit enters the first stage
  function automatic sas_pkg::stage_t shift_in(input sas_pkg::stage_t s,
                                               input logic            d);
    return {s[`SAS_STAGES-2:0], d};
  endfunction

  assign stage_next = rise ? shift_in(stage_reg, serial_in_i)
                           : stage_reg; // R1

  // reset value only gives simulation a known start

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stage_reg <= `SAS_STAGE_RST; // R10
    end
    else
    begin
      stage_reg <= stage_next; // R1
    end
  end

  // ---------------------------------------------------------------
  // storage latches
  // ---------------------------------------------------------------
  // transparent: takes the post-shift value in the same cycle
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      latch_reg <= `SAS_STAGE_RST; // R10
    end
    else if (latch_transfer_i)
    begin
      latch_reg <= stage_next; // R2 R5
    end
  end

  assign parallel_out_o = latch_reg; // R3 R4
  assign parallel_oe_o  = {`SAS_STAGES{output_enable_i}}; // R3

  // ---------------------------------------------------------------
  // cascade outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rise_out_reg <= 1'b0;
    end
    else if (rise)
    begin
      rise_out_reg <= stage_reg[`SAS_SEVENTH_IDX]; // R6 R8
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fall_out_reg <= 1'b0;
    end
    else if (fall)
    begin
      fall_out_reg <= stage_reg[`SAS_LAST_IDX]; // R7 R8
    end
  end

  assign serial_out_rise_o = rise_out_reg; // R8
  assign serial_out_fall_o = fall_out_reg; // R8

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_SHIFT: assert property ( // R1
    @(posedge clock_i) disable iff (!nrst_i)
    rise |=> stage_reg == shift_in($past(stage_reg), $past(serial_in_i)))
    else $error("shift chain did not advance on rising edge");

  AST_LATCH_FOLLOW: assert property ( // R2
    @(posedge clock_i) disable iff (!nrst_i)
    latch_transfer_i |=> latch_reg == stage_reg)
    else $error("latch did not follow stage while transparent");

  AST_LATCH_HOLD: assert property ( // R2
    @(posedge clock_i) disable iff (!nrst_i)
    !latch_transfer_i ##1 !latch_transfer_i [*2] |-> $stable(latch_reg))
    else $error("latch changed while transfer low");

  AST_DRIVE: assert property ( // R3
    @(posedge clock_i) disable iff (!nrst_i)
    (parallel_oe_o == 8'h00) == !output_enable_i)
    else $error("parallel drive does not match enable");

  AST_NO_TRANSFER: assert property ( // R4
    @(posedge clock_i) disable iff (!nrst_i)
    output_enable_i && !latch_transfer_i && rise |=> $stable(parallel_out_o))
    else $error("parallel outputs moved without transfer");

  AST_PAR_SHIFT: assert property ( // R5
    @(posedge clock_i) disable iff (!nrst_i)
    output_enable_i && latch_transfer_i && rise |=>
      parallel_out_o == {$past(stage_reg[6:0]), $past(serial_in_i)})
    else $error("parallel outputs did not shift");

  AST_RISE_OUT: assert property ( // R6
    @(posedge clock_i) disable iff (!nrst_i)
    rise |=> serial_out_rise_o == stage_reg[7] &&
             serial_out_rise_o == $past(stage_reg[6]))
    else $error("rise output not seventh stage value");

  AST_RISE_ONLY: assert property ( // R6
    @(posedge clock_i) disable iff (!nrst_i)
    !rise |=> $stable(serial_out_rise_o))
    else $error("rise output changed without rising edge");

  AST_FALL_OUT: assert property ( // R7
    @(posedge clock_i) disable iff (!nrst_i)
    fall |=> serial_out_fall_o == $past(stage_reg[7]) &&
             $stable(stage_reg) && $stable(serial_out_rise_o))
    else $error("falling edge handling wrong");

  AST_SERIAL_DISABLED: assert property ( // R8
    @(posedge clock_i) disable iff (!nrst_i)
    !output_enable_i && fall |=> serial_out_fall_o == $past(stage_reg[7]))
    else $error("fall output stalled while disabled");

  AST_STAGE_HOLD: assert property ( // R1
    @(posedge clock_i) disable iff (!nrst_i)
    !rise |=> $stable(stage_reg))
    else $error("shift chain moved without rising edge");

  AST_LATCH_LOAD: assert property ( // R2
    @(posedge clock_i) disable iff (!nrst_i)
    latch_transfer_i && rise |=>
      latch_reg == shift_in($past(stage_reg), $past(serial_in_i)))
    else $error("open latch missed the shifted value");

  AST_DRIVE_ALL: assert property ( // R3
    @(posedge clock_i) disable iff (!nrst_i)
    output_enable_i |-> parallel_oe_o == 8'hff)
    else $error("parallel drive incomplete while enabled");

  AST_LATCH_DISABLED: assert property ( // R3
    @(posedge clock_i) disable iff (!nrst_i)
    !output_enable_i && latch_transfer_i |=> parallel_out_o == stage_reg)
    else $error("latch stopped loading while outputs float");

  AST_IDLE_HOLD: assert property ( // R4
    @(posedge clock_i) disable iff (!nrst_i)
    !rise && !latch_transfer_i |=> $stable(parallel_out_o))
    else $error("parallel outputs moved while idle");

  AST_RISE_TRACKS: assert property ( // R6
    @(posedge clock_i) disable iff (!nrst_i)
    serial_out_rise_o == stage_reg[7])
    else $error("rise output differs from eighth stage");

  AST_FALL_ONLY: assert property ( // R7
    @(posedge clock_i) disable iff (!nrst_i)
    !fall |=> $stable(serial_out_fall_o))
    else $error("fall output changed without falling edge");

  AST_FALL_PAR: assert property ( // R7
    @(posedge clock_i) disable iff (!nrst_i)
    fall && !latch_transfer_i |=> $stable(parallel_out_o))
    else $error("parallel outputs moved on falling edge");

  AST_FALL_STAGE_HOLD: assert property ( // R7
    @(posedge clock_i) disable iff (!nrst_i)
    fall |=> $stable(stage_reg))
    else $error("shift chain moved on falling edge");

  AST_RISE_DISABLED: assert property ( // R8
    @(posedge clock_i) disable iff (!nrst_i)
    !output_enable_i && rise |=> serial_out_rise_o == $past(stage_reg[6]))
    else $error("rise output stalled while disabled");

endmodule // shift_and_store_register8

// *** test/host_model.sv ***
// host controller model: data, shift clock, strobe and enable
// assumes the design samples its inputs on rising clock_i
`timescale 1ns/1ps

module host_model
(
  input  wire logic clock_i,
  output logic      serial_in_o,
  output logic      shift_clock_o,
  output logic      latch_transfer_o,
  output logic      output_enable_o
);
  initial
  begin
    serial_in_o = 1'b0;
    shift_clock_o = 1'b0;
    latch_transfer_o = 1'b0;
    output_enable_o = 1'b0;
  end

  // one bit: shift clock high for one period, then driven low at return
  task automatic send(input logic d, input logic str, input logic en);
    @(negedge clock_i);
    serial_in_o = d;
    latch_transfer_o = str;
    output_enable_o = en;
    shift_clock_o = 1'b1;
    @(negedge clock_i);
    shift_clock_o = 1'b0;
  endtask
endmodule // host_model

// *** test/tb_shift_and_store_register8.sv ***
// bench: random and corner shift sequences against a reference model
// assumes host_model and the design files are compiled first
`timescale 1ns/1ps

module tb_shift_and_store_register8;
  logic            clock_i = 1'b0;
  logic            nrst_i = 1'b0;
  logic            sin, sclk, str, en, rise, fall, prev_fall;
  logic            rise_f, fall_s;
  sas_pkg::stage_t par, oe, stage, latch;
  sas_pkg::stage_t par_f, oe_f, par_s, oe_s, stage_c, latch_c;
  wire [7:0]       pbus;
  wire [7:0]       pbus_f;
  wire [7:0]       pbus_s;
  logic [31:0]     rnd = 32'h8d93_debc;
  int              err_count = 0;
  int              compares = 0;

  always #5 clock_i = ~clock_i;

  // parallel wire level from drive enables
  for (genvar i = 0; i < 8; i++)
  begin : g_wire
    assign pbus[i] = oe[i] ? par[i] : 1'bz;
    assign pbus_f[i] = oe_f[i] ? par_f[i] : 1'bz;
    assign pbus_s[i] = oe_s[i] ? par_s[i] : 1'bz;
  end

  host_model u_host_model (.clock_i(clock_i), .serial_in_o(sin),
    .shift_clock_o(sclk), .latch_transfer_o(str), .output_enable_o(en));

  shift_and_store_register8 u_shift_and_store_register8 (
    .clock_i(clock_i), .nrst_i(nrst_i), .serial_in_i(sin),
    .shift_clock_i(sclk), .latch_transfer_i(str), .output_enable_i(en),
    .parallel_out_o(par), .parallel_oe_o(oe),
    .serial_out_rise_o(rise), .serial_out_fall_o(fall));

  // cascade for fast clock edges: fed from the rise output
  shift_and_store_register8 u_shift_and_store_register8_fast (
    .clock_i(clock_i), .nrst_i(nrst_i), .serial_in_i(rise),
    .shift_clock_i(sclk), .latch_transfer_i(str), .output_enable_i(en),
    .parallel_out_o(par_f), .parallel_oe_o(oe_f),
    .serial_out_rise_o(rise_f), .serial_out_fall_o());

  // cascade for slow clock edges: fed from the fall output
  shift_and_store_register8 u_shift_and_store_register8_slow (
    .clock_i(clock_i), .nrst_i(nrst_i), .serial_in_i(fall),
    .shift_clock_i(sclk), .latch_transfer_i(str), .output_enable_i(en),
    .parallel_out_o(par_s), .parallel_oe_o(oe_s),
    .serial_out_rise_o(), .serial_out_fall_o(fall_s));

  function automatic logic [31:0] next_rnd(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [7:0] exp_bus(input logic [7:0] l, input logic e);
    return e ? l : 8'hzz;
  endfunction

  function automatic logic [7:0] shift_exp(input logic [7:0] s,
                                           input logic       d);
    return {s[6:0], d};
  endfunction

  task automatic check(input string n, input logic [7:0] e,
                       input logic [7:0] s);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic step(input logic d, input logic s, input logic e);
    prev_fall = stage[7];
    u_host_model.send(d, s, e);
    stage = shift_exp(stage, d);
    stage_c = shift_exp(stage_c, prev_fall);
    if (s)
    begin
      latch = stage;
      latch_c = stage_c;
    end
    check("rise", {7'h00, stage[7]}, {7'h00, rise});
    check("cascade bus fast", exp_bus(latch_c, e), pbus_f);
    check("cascade bus slow", exp_bus(latch_c, e), pbus_s);
    check("cascade rise", {7'h00, stage_c[7]}, {7'h00, rise_f});
    check("fall", {7'h00, prev_fall}, {7'h00, fall});
    check("bus", exp_bus(latch, e), pbus);
    @(negedge clock_i);
    check("fall", {7'h00, stage[7]}, {7'h00, fall});
    check("bus", exp_bus(latch, e), pbus);
    check("cascade fall", {7'h00, stage_c[7]}, {7'h00, fall_s});
  endtask

  task automatic end_sim();
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // first 8 bits hold the latches, next 8 follow them, then random
  initial
  begin
    stage = 8'h00;
    latch = 8'h00;
    stage_c = 8'h00;
    latch_c = 8'h00;
    repeat (16) @(negedge clock_i);
    nrst_i = 1'b1;
    for (int i = 0; i < 64; i++)
    begin
      rnd = next_rnd(rnd);
      step(rnd[0], (i < 8) ? 1'b0 : (i < 16) ? 1'b1 : rnd[1], i < 16 | rnd[2]);
    end
    // corner: ones then zeros through open latches, drive toggling
    for (int i = 0; i < 16; i++)
    begin
      step(i < 8, 1'b1, i[0]);
    end
    end_sim();
  end
endmodule // tb_shift_and_store_register8
